// *** verilog/spm_pkg.sv ***
// Purpose: shared constants and types of the serial port (modes 0 and 1)
// Assumes: AHB-Lite register access, clk is the oscillator
// Notes: offsets are byte addresses of 32-bit words
package spm_pkg;

  // register map
  localparam logic [31:0] SPM_BUF_ADDR = 32'h0000_0000;
  localparam logic [31:0] SPM_CTL_ADDR = 32'h0000_0004;
  localparam int SPM_CTL_WIDTH = 9;

  // control and status word, high bit first in the register
  typedef struct packed {
    logic fast_baud;
    logic mode_select_high;
    logic mode_select_low;
    logic speed_or_multiproc_bit;
    logic rx_enable;
    logic spare;
    logic received_ninth_bit;
    logic transmit_complete_flag;
    logic receive_flag;
  } spm_ctrl_t;

  localparam spm_ctrl_t SPM_CTL_RESET = '0;

  // mode codes {high, low}
  localparam logic [1:0] SPM_MODE0 = 2'h0;
  localparam logic [1:0] SPM_MODE1 = 2'h1;

  // mode 0 shift cell timing, in oscillator periods
  localparam logic [3:0] SPM_M0_PERIOD_FAST = 4'h4;
  localparam logic [3:0] SPM_M0_PERIOD_SLOW = 4'hc;
  localparam logic [3:0] SPM_M0_LEAD_FAST = 4'h1;
  localparam logic [3:0] SPM_M0_LEAD_SLOW = 4'h3;
  localparam logic [3:0] SPM_M0_LOW_FAST = 4'h2;
  localparam logic [3:0] SPM_M0_LOW_SLOW = 4'h6;
  localparam logic [2:0] SPM_M0_LAST_BIT = 3'h7;

  // mode 1 sixteenth-bit counter
  localparam logic [3:0] SPM_DIV_LAST = 4'hf;
  localparam logic [3:0] SPM_SMP_A = 4'h7;
  localparam logic [3:0] SPM_SMP_B = 4'h8;
  localparam logic [3:0] SPM_SMP_C = 4'h9;
  localparam logic [3:0] SPM_TX_STOP_IDX = 4'h9;
  localparam logic [3:0] SPM_RX_STOP_IDX = 4'h9;

  // line levels
  localparam logic SPM_START_BIT = 1'b0;
  localparam logic SPM_STOP_BIT = 1'b1;

endpackage

// *** verilog/spm_sync2.sv ***
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to clk
// Notes: resets to the idle line level (high)
`timescale 1ns/100ps
module spm_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // level
  input wire logic async_in,
  output logic sync_out
);

  logic meta;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // spm_sync2

// *** verilog/spm_serial_port.sv ***
// Purpose: serial port, synchronous mode 0 and ten-bit asynchronous mode 1
// Assumes: clk is the oscillator; timer_overflow is a one-cycle pulse on clk
// Notes: registers on AHB-Lite, zero wait states, always OKAY
`timescale 1ns/100ps
module spm_serial_port
  import spm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // bit-rate source
  input wire logic timer_overflow,
  // serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n
);

  import spm_pkg::*;

  typedef enum logic [2:0] {
    M0_IDLE = 3'b001,
    M0_TX = 3'b010,
    M0_RX = 3'b100
  } spm_m0_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } spm_tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_RECV = 2'b10
  } spm_rx_state_t;

  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // ---------------- bus slave ----------------
  spm_ctrl_t ctl;
  spm_ctrl_t next_ctl;
  logic [7:0] rx_buffer;
  logic ap_valid;
  logic ap_write;
  logic ap_buf;
  logic ap_ctl;

  wire take = hsel & htrans[1] & hready;
  wire hit_buf = (haddr == SPM_BUF_ADDR);
  wire hit_ctl = (haddr == SPM_CTL_ADDR);
  wire [31:0] rd_word = hit_buf ? {24'h00_0000, rx_buffer} :
                        hit_ctl ? {23'h00_0000, ctl} : 32'h0000_0000;
  wire wr_buf = ap_valid & ap_write & ap_buf;
  wire wr_ctl = ap_valid & ap_write & ap_ctl;

  // hsize is not checked: only whole-word singles are expected
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_buf <= 1'b0;
      ap_ctl <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_valid <= take;
      ap_write <= hwrite;
      ap_buf <= hit_buf;
      ap_ctl <= hit_ctl;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // ---------------- mode decode ----------------
  wire [1:0] mode = {ctl.mode_select_high, ctl.mode_select_low};
  wire mode0 = (mode == SPM_MODE0);
  wire mode1 = (mode == SPM_MODE1);
  wire speed = ctl.speed_or_multiproc_bit;

  logic rxd_s;

  spm_sync2 u_rxd_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(rxd_in),
    .sync_out(rxd_s)
  );

  // ---------------- mode 0 engine ----------------
  spm_m0_state_t m0_state;
  spm_m0_state_t next_m0;
  logic [3:0] m0_cnt;
  logic [2:0] m0_bits;
  logic [9:0] tx_frame;
  logic [7:0] rx_shift;

  wire [3:0] m0_period = speed ? SPM_M0_PERIOD_FAST : SPM_M0_PERIOD_SLOW;
  wire [3:0] m0_fall_at = speed ? SPM_M0_LEAD_FAST : SPM_M0_LEAD_SLOW;
  wire [3:0] m0_rise_at = speed ? (SPM_M0_LEAD_FAST + SPM_M0_LOW_FAST)
                                : (SPM_M0_LEAD_SLOW + SPM_M0_LOW_SLOW);
  wire m0_last = (m0_cnt == m0_period - 4'h1);
  wire m0_rise = (m0_cnt == m0_rise_at);
  wire m0_idle = (m0_state == M0_IDLE);
  wire m0_in_tx = (m0_state == M0_TX);
  wire m0_in_rx = (m0_state == M0_RX);
  wire m0_start_tx = mode0 & wr_buf;
  wire m0_start_rx = mode0 & m0_idle & ctl.rx_enable & ~ctl.receive_flag & ~wr_buf;
  wire m0_end = m0_last & (m0_bits == SPM_M0_LAST_BIT);
  wire m0_tx_done = m0_in_tx & m0_end;
  wire m0_rx_done = m0_in_rx & m0_end;

  always_comb begin
    next_m0 = m0_state;
    unique case (m0_state)
      M0_IDLE: next_m0 = m0_start_tx ? M0_TX : (m0_start_rx ? M0_RX : M0_IDLE);
      M0_TX: next_m0 = m0_tx_done ? M0_IDLE : M0_TX;
      // a buffer write takes the line over from a receive in progress
      M0_RX: next_m0 = m0_start_tx ? M0_TX : (m0_rx_done ? M0_IDLE : M0_RX);
      default: next_m0 = M0_IDLE;
    endcase
    if (!mode0) begin
      next_m0 = M0_IDLE;
    end
  end

  wire m0_restart = m0_start_tx | m0_idle;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m0_state <= M0_IDLE;
      m0_cnt <= 4'h0;
      m0_bits <= 3'h0;
    end else begin
      m0_state <= next_m0;
      if (m0_restart) begin
        m0_cnt <= 4'h0;
        m0_bits <= 3'h0;
      end else begin
        m0_cnt <= m0_last ? 4'h0 : m0_cnt + 4'h1;
        m0_bits <= m0_last ? m0_bits + 3'h1 : m0_bits;
      end
    end
  end

  // ---------------- mode 1 bit-rate ticks ----------------
  logic half_tg;
  logic [3:0] tx_div;
  wire tick16 = timer_overflow & (ctl.fast_baud | half_tg);
  wire tx_roll = tick16 & (tx_div == SPM_DIV_LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_tg <= 1'b0;
      tx_div <= 4'h0;
    end else begin
      if (timer_overflow) begin
        half_tg <= ~half_tg;
      end
      if (tick16) begin
        tx_div <= tx_div + 4'h1;
      end
    end
  end

  // ---------------- mode 1 transmitter ----------------
  spm_tx_state_t tx_state;
  logic [3:0] tx_cnt;
  wire tx_step = mode1 & (tx_state == TX_SEND) & tx_roll;
  wire m1_tx_done = tx_step & (tx_cnt == SPM_TX_STOP_IDX);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
    end else if (mode1 && wr_buf) begin
      tx_state <= TX_SEND;
      tx_cnt <= 4'h0;
    end else if (!mode1 || m1_tx_done) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
    end else if (tx_step) begin
      tx_cnt <= tx_cnt + 4'h1;
    end
  end

  // ---------------- shared shift registers ----------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_frame <= 10'h3ff;
    end else if (wr_buf) begin
      tx_frame <= mode1 ? {SPM_STOP_BIT, hwdata[7:0], SPM_START_BIT}
                        : {2'h3, hwdata[7:0]};
    end else if ((m0_in_tx && m0_last) || tx_step) begin
      tx_frame <= {1'b1, tx_frame[9:1]};
    end
  end

  // ---------------- mode 1 receiver ----------------
  spm_rx_state_t rx_state;
  logic [3:0] rx_div;
  logic [3:0] rx_idx;
  logic rx_prev;
  logic smp_a;
  logic smp_b;

  wire rx_hunt = (rx_state == RX_HUNT);
  wire rx_fall = mode1 & rx_hunt & ctl.rx_enable & tick16 & rx_prev & ~rxd_s;
  wire rx_decide = (rx_state == RX_RECV) & tick16 & (rx_div == SPM_SMP_C);
  wire rx_bit = majority(smp_a, smp_b, rxd_s);
  wire rx_bad_start = rx_decide & (rx_idx == 4'h0) & (rx_bit != SPM_START_BIT);
  wire rx_at_stop = rx_decide & (rx_idx == SPM_RX_STOP_IDX);
  wire rx_accept = rx_at_stop & ~ctl.receive_flag & (~speed | rx_bit);
  wire rx_data_bit = rx_decide & (rx_idx != 4'h0) & ~rx_at_stop;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state <= RX_HUNT;
      rx_div <= 4'h0;
      rx_idx <= 4'h0;
    end else if (!mode1 || rx_bad_start || rx_at_stop) begin
      rx_state <= RX_HUNT;
    end else if (rx_fall) begin
      rx_state <= RX_RECV;
      rx_div <= 4'h0;
      rx_idx <= 4'h0;
    end else if (tick16 && !rx_hunt) begin
      rx_div <= rx_div + 4'h1;
      if (rx_div == SPM_DIV_LAST) begin
        rx_idx <= rx_idx + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_prev <= 1'b1;
      smp_a <= 1'b1;
      smp_b <= 1'b1;
    end else if (tick16) begin
      rx_prev <= rxd_s;
      if (rx_div == SPM_SMP_A) begin
        smp_a <= rxd_s;
      end
      if (rx_div == SPM_SMP_B) begin
        smp_b <= rxd_s;
      end
    end
  end

  // receive shift: mode 0 samples at the rising shift clock, mode 1 at decisions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift <= 8'h00;
    end else if (m0_in_rx && m0_rise) begin
      rx_shift <= {rxd_s, rx_shift[7:1]};
    end else if (rx_data_bit) begin
      rx_shift <= {rx_bit, rx_shift[7:1]};
    end
  end

  wire rx_load = m0_rx_done | rx_accept;
  // fast mode 0 shifts its last bit on the very edge that ends the frame
  wire [7:0] rx_byte = (m0_in_rx && m0_rise) ? {rxd_s, rx_shift[7:1]} : rx_shift;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_buffer <= 8'h00;
    end else if (rx_load) begin
      rx_buffer <= rx_byte;
    end
  end

  // ---------------- control and flags ----------------
  wire ti_set = m0_tx_done | m1_tx_done;
  wire ri_set = m0_rx_done | rx_accept;

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    next_ctl = ctl;
    if (wr_ctl) begin
      next_ctl = spm_ctrl_t'(hwdata[SPM_CTL_WIDTH-1:0]);
    end
    if (ti_set) begin
      next_ctl.transmit_complete_flag = 1'b1;
    end
    if (rx_accept) begin
      next_ctl.received_ninth_bit = rx_bit;
    end
    if (ri_set) begin
      next_ctl.receive_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= SPM_CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  // ---------------- pins ----------------
  wire m0_txd = m0_idle ? 1'b1 : (m0_cnt == m0_fall_at) ? 1'b0 : (m0_rise | txd);
  wire m1_txd = tx_step ? tx_frame[0] : txd;
  wire next_txd = mode0 ? m0_txd : (mode1 ? m1_txd : 1'b1);

  wire m0_drive = mode0 & m0_in_tx;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      txd <= next_txd;
      rxd_oe_n <= ~m0_drive;
      if (m0_drive && m0_cnt == 4'h0) begin
        rxd_out <= tx_frame[0];
      end
    end
  end

endmodule // spm_serial_port

// *** verif/spm_serial_port_assertions.sv ***
// Purpose: concurrent checks on the serial port top ports
// Assumes: mode 0 transmit is the only time rxd_oe_n is low
// Notes: mode 1 timing is judged by the bench, not here
`timescale 1ns/100ps
module spm_serial_port_assertions
  import spm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe_n
);
  logic txd_q;
  logic [3:0] n_fall;
  wire fall_m0 = txd_q && !txd && !rxd_oe_n;
  wire [3:0] next_n_fall = rxd_oe_n ? 4'h0 : n_fall + {3'h0, fall_m0};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_q <= 1'b1;
      n_fall <= 4'h0;
    end else begin
      txd_q <= txd;
      n_fall <= next_n_fall;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  // low for two clocks (fast) or six (slow), then high
  sequence low_cell;
    !txd ##1 (txd or (!txd [*4] ##1 txd));
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_reset_idle: assert property (disable iff (1'b0)
    sys_rst ##1 sys_rst |-> txd && rxd_out && rxd_oe_n && hreadyout && !hresp)
    else $error("pins not idle in reset");
  chk_shift_low: assert property ($fell(txd) && !rxd_oe_n |=> low_cell)
    else $error("shift clock low time wrong");
  chk_data_lead: assert property ($fell(txd) && !rxd_oe_n |-> $stable(rxd_out))
    else $error("data changed at clock fall");
  chk_data_stable: assert property (!txd && !rxd_oe_n |=> $stable(rxd_out))
    else $error("data changed while clock low");
  chk_eight_bits: assert property ($rose(rxd_oe_n) |-> n_fall == 4'h8)
    else $error("frame not eight clocks");
  chk_release_high: assert property ($rose(rxd_oe_n) |-> txd)
    else $error("shift clock low at release");
  chk_hrdata_hold: assert property (!$past(hsel && htrans[1] && hready && !hwrite)
    |-> $stable(hrdata)) else $error("read data moved");
  chk_unmapped_zero: assert property (rd_taken ##0 (haddr != SPM_BUF_ADDR
    && haddr != SPM_CTL_ADDR) |=> hrdata == 32'h0) else $error("unmapped read not 0");
  chk_upper_zero: assert property (rd_taken ##0 haddr == SPM_BUF_ADDR
    |=> hrdata[31:8] == 24'h0) else $error("buffer upper bits set");
endmodule // spm_serial_port_assertions

// *** verif/spm_peer.sv ***
// Purpose: far-side shift device (mode 0) or async sender (mode 1)
// Assumes: bit time of 64 clocks in mode 1
// Notes: short_start makes a start bit of two ticks only
`timescale 1ns/100ps
module spm_peer (
  // clock
  input wire logic clk,
  // bench control
  input wire logic go,
  input wire logic m1_mode,
  input wire logic short_start,
  input wire logic [7:0] tx_byte,
  // link
  input wire logic txd,
  output logic rxd_drv
);
  logic [9:0] fr = '1;
  logic txd_q = 1'b1;
  int nb = 0;
  int cnt = 0;
  initial rxd_drv = 1'b1;
  always @(posedge clk) begin
    txd_q <= txd;
    if (go) begin
      fr <= {1'b1, tx_byte, 1'b0};
      nb <= m1_mode ? 10 : 8;
      cnt <= short_start ? 8 : 64;
      if (m1_mode) rxd_drv <= 1'b0;
    end else if (m1_mode) begin
      if (nb == 0) rxd_drv <= 1'b1;
      else if (cnt > 1) cnt <= cnt - 1;
      else begin
        nb <= nb - 1;
        cnt <= 64;
        rxd_drv <= fr[1];
        fr <= {1'b1, fr[9:1]};
      end
    end else if (txd_q && !txd && nb > 0) begin
      rxd_drv <= fr[1];
      fr <= {1'b1, fr[9:1]};
      nb <= nb - 1;
    end else if (!txd_q && txd && nb == 0) rxd_drv <= ~rxd_drv;
  end
endmodule // spm_peer

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the serial port
// Assumes: timer overflow every 4 clocks, fast_baud set in mode 1 but for one transmit
// Notes: mode 0 receive uses the slow rate for line settling margin
`timescale 1ns/100ps
module tb_top;
  import spm_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, ovf = 0, go = 0, m1 = 0, shrt = 0;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic [1:0] htrans = '0, oc = '0;
  logic [7:0] pb = '0;
  logic [9:0] got;
  logic hreadyout, hresp, txd, rxd_out, rxd_oe_n, pdrv;
  int n_errors = 0, n_compared = 0, k;
  wire rxd = rxd_oe_n ? pdrv : rxd_out;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    oc <= oc + 2'h1;
    ovf <= (oc == 2'h3);
  end
  spm_serial_port spm_serial_port_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_overflow(ovf), .txd(txd), .rxd_in(rxd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
  spm_peer spm_peer_i (.clk(clk), .go(go), .m1_mode(m1), .short_start(shrt),
    .tx_byte(pb), .txd(txd), .rxd_drv(pdrv));
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h want %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send(input logic mode1, input logic s, input logic [7:0] b);
    @(posedge clk);
    m1 <= mode1;
    shrt <= s;
    pb <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic edge_wait(input logic v);
    do @(posedge clk); while (txd !== v);
  endtask
  task automatic t_reset;
    chk(32'({txd, rxd_out, rxd_oe_n}), 32'h7);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'(SPM_CTL_RESET));
    xfer(1, 32'h8, 32'hffff_ffff);
    xfer(0, 32'h8, 0);
    chk(rd, 32'h0);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h0);
  endtask
  task automatic t_m0_tx(input logic sp, input logic [7:0] b);
    xfer(1, SPM_CTL_ADDR, {26'h0, sp, 5'h0});
    xfer(1, SPM_BUF_ADDR, {24'h0, b});
    for (int i = 0; i < 8; i++) begin
      edge_wait(0);
      edge_wait(1);
      got[i] = rxd_out;
    end
    chk({24'h0, got[7:0]}, {24'h0, b});
    repeat (40) @(posedge clk);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, {26'h0, sp, 5'h2});
  endtask
  task automatic t_m0_rx;
    send(0, 0, 8'h3c);
    xfer(1, SPM_CTL_ADDR, 32'h010);
    repeat (8) begin
      edge_wait(0);
      edge_wait(1);
    end
    repeat (20) @(posedge clk);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h011);
    xfer(0, SPM_BUF_ADDR, 0);
    chk(rd, 32'h3c);
    k = 0;
    repeat (200) begin
      @(posedge clk);
      if (txd !== 1'b1) k++;
    end
    chk(32'(k), 32'h0);
    m1 <= 1'b1;
  endtask
  task automatic t_m1(input logic [7:0] tb_b, input logic [7:0] pb_b);
    xfer(1, SPM_CTL_ADDR, 32'h150);
    send(1, 0, pb_b);
    xfer(1, SPM_BUF_ADDR, {24'h0, tb_b});
    edge_wait(0);
    repeat (32) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = txd;
      repeat (64) @(posedge clk);
    end
    chk({22'h0, got}, {22'h0, 1'b1, tb_b, 1'b0});
    repeat (20) @(posedge clk);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h157);
    xfer(0, SPM_BUF_ADDR, 0);
    chk(rd, {24'h0, pb_b});
  endtask
  task automatic t_m1_drop;
    xfer(1, SPM_CTL_ADDR, 32'h150);
    send(1, 1, 8'hff);
    repeat (700) @(posedge clk);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h150);
    send(1, 0, 8'h81);
    repeat (700) @(posedge clk);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h155);
    send(1, 0, 8'h7e);
    repeat (700) @(posedge clk);
    xfer(0, SPM_BUF_ADDR, 0);
    chk(rd, 32'h81);
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h155);
  endtask
  task automatic t_m1_slow(input logic [7:0] b);
    xfer(1, SPM_CTL_ADDR, 32'h040);
    xfer(1, SPM_BUF_ADDR, {24'h0, b});
    edge_wait(0);
    repeat (64) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = txd;
      repeat (128) @(posedge clk);
    end
    chk({22'h0, got}, {22'h0, 1'b1, b, 1'b0});
    xfer(0, SPM_CTL_ADDR, 0);
    chk(rd, 32'h042);
  endtask
  initial begin
    repeat (12000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_m0_tx(1'b1, 8'ha5);
    t_m0_tx(1'b0, 8'h96);
    t_m0_rx();
    t_m1(8'h5a, 8'h96);
    t_m1_drop();
    t_m1_slow(8'hc3);
    stop_test();
  end
endmodule // tb_top
bind spm_serial_port spm_serial_port_assertions spm_serial_port_assertions_i (.clk(clk),
  .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd),
  .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
